// [shared/ric_cfg.svh]
// constants for the reset and interrupt control block
`ifndef RIC_CFG_SVH
`define RIC_CFG_SVH

// interrupt source layout: pins first, then peripherals
`define RIC_NPIN 8
`define RIC_NPER 8
`define RIC_NSRC 16
`define RIC_PRIO_W 2
`define RIC_LVL_NONE 3'h4
`define RIC_VEC_W 5
`define RIC_BRK_VEC 5'h10

// opcode that is never a legal instruction
`define RIC_ILL_OPCODE 8'hff

// interrupt response window in system clock cycles
`define RIC_RESP_MIN 9
`define RIC_RESP_MAX 16
`define RIC_RESP_CYC 4'h9

// minimum reset width for one-cycle reset events, cycles
`define RIC_RST_HOLD 5'h10

// reset cause bit positions
`define RIC_CAUSE_PIN 0
`define RIC_CAUSE_WDT 1
`define RIC_CAUSE_POR 2
`define RIC_CAUSE_LVD 3
`define RIC_CAUSE_ILL 4
`define RIC_CAUSE_PAR 5
`define RIC_CAUSE_MEM 6
`define RIC_NCAUSE 7

`endif

// [shared/ric_pkg.sv]
// types for the reset and interrupt control block
`include "ric_cfg.svh"
package ric_pkg;
	typedef enum logic [2:0] {
		RIC_IDLE = 3'b001,
		RIC_REQ = 3'b010,
		RIC_RESP = 3'b100
	} ric_state_e;
	typedef logic [`RIC_PRIO_W-1:0] ric_prio_t;
	typedef logic [`RIC_VEC_W-1:0] ric_vec_t;
	typedef logic [`RIC_NSRC-1:0] ric_src_t;
endpackage

// [rtl/ric_sync.sv]
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/100ps
module ric_sync import ric_pkg::*; #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule

// [rtl/ric_top.sv]
// reset source collection and vectored interrupt control
`timescale 1ns/100ps
`include "ric_cfg.svh"
// Operation
// - the external reset pin puts the whole device into reset
// - a watchdog program loop detection raises an internal reset
// - the power-on detector below its threshold raises an internal reset
// - the low_voltage_detector below its threshold raises an internal reset
// - executing opcode ff raises reset, except under debug emulation
// - a RAM parity error raises an internal reset
// - an illegal memory access raises an internal reset
// - a masked maskable request is never serviced
// - each maskable source sits in one of four priority groups
// - a higher priority request may interrupt a lower one in service
// - equal priority requests are served in fixed source index order
// - an unmasked pending request releases STOP, HALT and low_power_a
// - maskable requests come from both pins and peripherals
// - the software_break_instruction raises a vectored software interrupt
// - the software break is taken even with interrupts disabled
// - the software break ignores priority ranking of maskable requests
// - response from acceptance to handler start is 9 to 16 cycles
module ric_top import ric_pkg::*; (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic RESET_PIN_IN,
	input wire logic POR_DETECT_IN,
	input wire logic LOW_VOLTAGE_DETECTOR_IN,
	input wire logic WDT_LOOP_IN,
	input wire logic EXEC_STROBE_IN,
	input wire logic [7:0] OPCODE_IN,
	input wire logic DEBUG_EMU_IN,
	input wire logic RAM_PARITY_ERR_IN,
	input wire logic ILLEGAL_ACCESS_IN,
	input wire logic [`RIC_NPIN-1:0] INT_PIN_IN,
	input wire logic [`RIC_NPER-1:0] PERIPH_REQ_IN,
	input wire logic [`RIC_NSRC-1:0] INT_MASK_IN,
	input wire logic [2*`RIC_NSRC-1:0] INT_PRIO_IN,
	input wire logic INT_ENABLE_IN,
	input wire logic BREAK_EXEC_IN,
	input wire logic INT_ACK_IN,
	input wire logic INT_RETURN_IN,
	output logic SYS_RESET_OUT,
	output logic [`RIC_NCAUSE-1:0] RESET_CAUSE_OUT,
	output logic INT_REQ_OUT,
	output logic [`RIC_VEC_W-1:0] INT_VECTOR_OUT,
	output logic INT_START_OUT,
	output logic [`RIC_NSRC-1:0] INT_FLAGS_OUT,
	output logic [3:0] IN_SERVICE_OUT,
	output logic STANDBY_RELEASE_OUT
);
	// best eligible source: strict compare keeps the lowest index on ties
	function automatic logic [4:0] pick_src(input ric_src_t elig,
			input logic [2*`RIC_NSRC-1:0] prio);
		logic [2:0] best;
		logic [4:0] res;
		best = `RIC_LVL_NONE;
		res = 5'h00;
		for (int i = 0; i < `RIC_NSRC; i++) begin
			if (elig[i] && ({1'b0, prio[2*i +: 2]} < best)) begin
				best = {1'b0, prio[2*i +: 2]};
				res = {1'b1, i[3:0]};
			end
		end
		return res;
	endfunction

	// level of the highest priority group now in service
	function automatic logic [2:0] cur_level(input logic [3:0] isr);
		logic [2:0] lvl;
		lvl = `RIC_LVL_NONE;
		for (int i = 3; i >= 0; i--) begin
			if (isr[i]) begin
				lvl = i[2:0];
			end
		end
		return lvl;
	endfunction

	logic [`RIC_NPIN-1:0] pin_s;
	logic [2:0] lvl_s;
	logic rst_pin_s;
	logic por_s;
	logic lvd_s;
	logic ill_opc;
	logic event_rst;
	logic level_rst;
	logic [4:0] hold_q;
	logic [4:0] hold_d;
	logic sys_rst_q;
	logic [`RIC_NCAUSE-1:0] cause_q;
	logic [`RIC_NCAUSE-1:0] cause_set;
	logic [`RIC_NPIN-1:0] pin_prev_q;
	ric_src_t req_set;
	ric_src_t req_clr;
	ric_src_t flag_q;
	ric_src_t flag_d;
	ric_src_t elig;
	logic [4:0] pick;
	logic [2:0] lvl_now;
	logic brk_q;
	logic brk_d;
	ric_state_e state_q;
	ric_state_e state_d;
	ric_vec_t vec_q;
	ric_prio_t pri_q;
	logic accept;
	logic take_brk;
	logic take_int;
	logic resp_done;
	logic [3:0] cnt_q;
	logic [3:0] isr_q;
	logic [3:0] isr_push;
	logic [3:0] isr_pop;

	// pins and supply comparators are asynchronous to the clock
	ric_sync #(.WIDTH(`RIC_NPIN + 3)) u_sync (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.async_in({INT_PIN_IN, RESET_PIN_IN, POR_DETECT_IN, LOW_VOLTAGE_DETECTOR_IN}),
		.sync_out({pin_s, lvl_s})
	);
	assign rst_pin_s = lvl_s[2];
	assign por_s = lvl_s[1];
	assign lvd_s = lvl_s[0];

	assign ill_opc = EXEC_STROBE_IN && (OPCODE_IN == `RIC_ILL_OPCODE) && !DEBUG_EMU_IN;
	assign event_rst = WDT_LOOP_IN | ill_opc | RAM_PARITY_ERR_IN | ILLEGAL_ACCESS_IN;
	assign level_rst = rst_pin_s | por_s | lvd_s;
	// events are stretched so the rest of the chip sees a usable width
	assign hold_d = event_rst ? `RIC_RST_HOLD : ((hold_q != 5'h00) ? hold_q - 5'h01 : 5'h00);

	// cause record for software to read after restart
	assign cause_set = {ILLEGAL_ACCESS_IN, RAM_PARITY_ERR_IN, ill_opc, lvd_s,
		por_s, WDT_LOOP_IN, rst_pin_s};

	// level sources force reset until they deassert, events hold it 16 cycles after the last one
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			hold_q <= 5'h00;
			sys_rst_q <= 1'b1;
			cause_q <= '0;
		end else begin
			hold_q <= hold_d;
			sys_rst_q <= level_rst | event_rst | (hold_d != 5'h00);
			cause_q <= cause_set | (cause_q & {`RIC_NCAUSE{1'b1}});
		end
	end

	// pins are edge detected, peripherals give request pulses
	assign req_set = {PERIPH_REQ_IN, pin_s & ~pin_prev_q};
	assign req_clr = (accept && vec_q[4] == 1'b0) ?
		ric_src_t'(1) << vec_q[3:0] : '0;
	// a new request wins over the acknowledge clear
	assign flag_d = (flag_q & ~req_clr) | req_set;

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			pin_prev_q <= '0;
			flag_q <= '0;
		end else if (sys_rst_q) begin
			pin_prev_q <= pin_s;
			flag_q <= '0;
		end else begin
			pin_prev_q <= pin_s;
			flag_q <= flag_d;
		end
	end

	// only groups above the level in service may nest
	assign lvl_now = cur_level(isr_q);
	assign elig = flag_q & ~INT_MASK_IN & {`RIC_NSRC{INT_ENABLE_IN}};
	assign pick = pick_src(elig, INT_PRIO_IN);
	assign take_int = pick[4] && ({1'b0, INT_PRIO_IN[2*pick[3:0] +: 2]} < lvl_now);
	// break is not ranked, it simply goes first
	assign take_brk = brk_q;
	// wake from standby on any unmasked pending request
	assign STANDBY_RELEASE_OUT = |(flag_q & ~INT_MASK_IN);

	assign accept = (state_q == RIC_REQ) && INT_ACK_IN;
	assign resp_done = (state_q == RIC_RESP) && (cnt_q == 4'h0);
	// break request held until the core takes it
	assign brk_d = BREAK_EXEC_IN | (brk_q & ~(accept && vec_q == `RIC_BRK_VEC));

	// request and response sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			RIC_IDLE: begin
				if (take_brk || take_int) begin
					state_d = RIC_REQ;
				end
			end
			RIC_REQ: begin
				if (INT_ACK_IN) begin
					state_d = RIC_RESP;
				end
			end
			RIC_RESP: begin
				if (cnt_q == 4'h0) begin
					state_d = RIC_IDLE;
				end
			end
			default: begin
				state_d = RIC_IDLE;
			end
		endcase
	end

	// in-service groups: push on maskable accept, pop highest on return
	assign isr_push = (accept && vec_q != `RIC_BRK_VEC) ? 4'h1 << pri_q : 4'h0;
	assign isr_pop = (INT_RETURN_IN && lvl_now != `RIC_LVL_NONE) ?
		4'h1 << lvl_now[1:0] : 4'h0;

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_q <= RIC_IDLE;
			brk_q <= 1'b0;
			vec_q <= '0;
			pri_q <= '0;
			cnt_q <= 4'h0;
			isr_q <= 4'h0;
		end else if (sys_rst_q) begin
			state_q <= RIC_IDLE;
			brk_q <= 1'b0;
			cnt_q <= 4'h0;
			isr_q <= 4'h0;
		end else begin
			state_q <= state_d;
			brk_q <= brk_d;
			isr_q <= (isr_q & ~isr_pop) | isr_push;
			if (state_q == RIC_IDLE && take_brk) begin
				vec_q <= `RIC_BRK_VEC;
			end else if (state_q == RIC_IDLE && take_int) begin
				vec_q <= {1'b0, pick[3:0]};
				pri_q <= INT_PRIO_IN[2*pick[3:0] +: 2];
			end
			if (accept) begin
				cnt_q <= `RIC_RESP_CYC - 4'h1;
			end else if (state_q == RIC_RESP && cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end

	assign SYS_RESET_OUT = sys_rst_q;
	assign RESET_CAUSE_OUT = cause_q;
	assign INT_REQ_OUT = (state_q == RIC_REQ);
	assign INT_VECTOR_OUT = vec_q;
	assign INT_START_OUT = resp_done;
	assign INT_FLAGS_OUT = flag_q;
	assign IN_SERVICE_OUT = isr_q;

	// checks on the design's outputs and internal signals
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);

	logic [4:0] since_acc_q;
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			since_acc_q <= 5'h00;
		end else if (accept) begin
			since_acc_q <= 5'h01;
		end else if (since_acc_q != 5'h00 && since_acc_q != 5'h1f) begin
			since_acc_q <= since_acc_q + 5'h01;
		end
	end

	pin_reset_a: assert property (rst_pin_s |=> SYS_RESET_OUT)
		else $error("reset pin did not reset the device");
	wdt_reset_a: assert property (WDT_LOOP_IN |=> SYS_RESET_OUT [*8])
		else $error("watchdog reset too short");
	por_reset_a: assert property (por_s |=> SYS_RESET_OUT)
		else $error("power-on detector did not reset");
	lvd_reset_a: assert property (lvd_s |=> SYS_RESET_OUT)
		else $error("voltage detector did not reset");
	ill_opcode_a: assert property (EXEC_STROBE_IN && OPCODE_IN == `RIC_ILL_OPCODE
		&& DEBUG_EMU_IN && !SYS_RESET_OUT && !level_rst && hold_q == 5'h00
		&& !WDT_LOOP_IN && !RAM_PARITY_ERR_IN && !ILLEGAL_ACCESS_IN
		|=> !SYS_RESET_OUT)
		else $error("opcode ff reset under debug emulation");
	parity_reset_a: assert property (RAM_PARITY_ERR_IN |=> SYS_RESET_OUT)
		else $error("parity error did not reset");
	mem_reset_a: assert property (ILLEGAL_ACCESS_IN |=> SYS_RESET_OUT ##1 RESET_CAUSE_OUT[6])
		else $error("illegal access did not reset");
	mask_gate_a: assert property ($rose(INT_REQ_OUT) && !INT_VECTOR_OUT[4]
		|-> !(|($past(INT_MASK_IN) & (ric_src_t'(1) << INT_VECTOR_OUT[3:0]))))
		else $error("masked source was requested");
	nest_prio_a: assert property ($rose(INT_REQ_OUT) && !INT_VECTOR_OUT[4]
		|-> (IN_SERVICE_OUT & ((4'h2 << pri_q) - 4'h1)) == 4'h0)
		else $error("nested request not above level in service");
	wake_up_a: assert property ($rose(INT_REQ_OUT) && !INT_VECTOR_OUT[4]
		|-> $past(STANDBY_RELEASE_OUT))
		else $error("standby not released");
	brk_take_a: assert property (state_q == RIC_IDLE && brk_q && !sys_rst_q
		|=> INT_REQ_OUT && INT_VECTOR_OUT == `RIC_BRK_VEC)
		else $error("break not taken");
	resp_time_a: assert property (accept && !sys_rst_q
		|-> ##[`RIC_RESP_MIN:`RIC_RESP_MAX] INT_START_OUT)
		else $error("interrupt response outside window");
	resp_early_a: assert property (INT_START_OUT |-> since_acc_q >= 5'h09)
		else $error("handler started too early");
	flag_hold_a: assert property (INT_FLAGS_OUT[0] && !sys_rst_q && !(accept &&
		vec_q == 5'h00) |=> INT_FLAGS_OUT[0])
		else $error("request flag lost without acknowledge");

	nest_seen_c: cover property (isr_q[2] ##[1:100] isr_q[0] && isr_q[2]);
	brk_seen_c: cover property (accept && vec_q == `RIC_BRK_VEC);
	start_seen_c: cover property (INT_START_OUT && INT_VECTOR_OUT[4] == 1'b0);
	ill_seen_c: cover property (ill_opc ##1 SYS_RESET_OUT);
endmodule

// [sim/ric_core_model.sv]
// processor core stand-in that acknowledges vectored requests
`timescale 1ns/100ps
module ric_core_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic start_in,
	input wire logic [3:0] wait_in,
	output logic ack_out = 1'b0,
	output int resp_out
);
	int wait_q;
	int cnt_q;
	logic done_q;
	// one ack per request, dropped after the edge that took it
	always @(negedge clk_in) begin
		if (rst_in || !req_in) begin
			ack_out <= 1'b0;
			wait_q <= 0;
			done_q <= 1'b0;
		end else if (ack_out) begin
			ack_out <= 1'b0;
			done_q <= 1'b1;
		end else if (!done_q) begin
			// slow answers let the request stand for a while
			ack_out <= (wait_q >= int'(wait_in));
			wait_q <= wait_q + 1;
		end
	end
	// edges from the taken ack to the handler start, ack edge counted as one
	always @(posedge clk_in) begin
		if (ack_out && req_in)
			cnt_q <= 1;
		else
			cnt_q <= cnt_q + 1;
		if (start_in)
			resp_out <= cnt_q;
	end
endmodule

// [sim/reset_and_interrupt_control_tb.sv]
// self-checking bench for reset and interrupt control
`timescale 1ns/100ps
`include "ric_cfg.svh"
module reset_and_interrupt_control_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rpin = 1'b0, por = 1'b0, low_voltage_detector = 1'b0, wdt = 1'b0, exe = 1'b0, dbg = 1'b0;
	logic par = 1'b0, mem = 1'b0, software_break_instruction = 1'b0, ie = 1'b0, ret = 1'b0;
	logic [7:0] opc = 8'h00, ipin = 8'h00, preq = 8'h00;
	logic [15:0] msk = 16'hffff;
	logic [31:0] pri = 32'hffffffff;
	logic [3:0] waitv = 4'h0;
	wire ack, srst, req, start, stby;
	wire [6:0] cause;
	wire [4:0] vec;
	wire [15:0] flags;
	wire [3:0] insrv;
	int resp;
	int miscompares = 0;
	int cmp_count = 0;
	int bit_i[4] = '{1, 4, 5, 6};
	ric_top i_ric_top (.CLOCK_IN(clk), .RST_IN(rst), .RESET_PIN_IN(rpin),
		.POR_DETECT_IN(por), .LOW_VOLTAGE_DETECTOR_IN(low_voltage_detector), .WDT_LOOP_IN(wdt),
		.EXEC_STROBE_IN(exe), .OPCODE_IN(opc), .DEBUG_EMU_IN(dbg), .RAM_PARITY_ERR_IN(par),
		.ILLEGAL_ACCESS_IN(mem), .INT_PIN_IN(ipin), .PERIPH_REQ_IN(preq), .INT_MASK_IN(msk),
		.INT_PRIO_IN(pri), .INT_ENABLE_IN(ie), .BREAK_EXEC_IN(software_break_instruction), .INT_ACK_IN(ack),
		.INT_RETURN_IN(ret), .SYS_RESET_OUT(srst), .RESET_CAUSE_OUT(cause),
		.INT_REQ_OUT(req), .INT_VECTOR_OUT(vec), .INT_START_OUT(start),
		.INT_FLAGS_OUT(flags), .IN_SERVICE_OUT(insrv), .STANDBY_RELEASE_OUT(stby));
	ric_core_model i_ric_core_model (.clk_in(clk), .rst_in(rst), .req_in(req),
		.start_in(start), .wait_in(waitv), .ack_out(ack), .resp_out(resp));
	// free-running system clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic pick(input int s);
		return s == 0 ? srst : s == 1 ? req : start;
	endfunction
	// bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_on(input int s, input logic lvl, input int lim);
		int n;
		n = 0;
		while (pick(s) !== lvl) begin
			cyc(1);
			n++;
			if (n > lim) begin
				chk("wait bound", 0, 1);
				finish_test();
			end
		end
	endtask
	task automatic ret1();
		ret <= 1'b1;
		cyc(1);
		ret <= 1'b0;
		cyc(1);
	endtask
	// one request through to handler start
	task automatic serve(input logic [4:0] v, input logic [3:0] dly);
		waitv <= dly;
		wait_on(1, 1'b1, 12);
		chk("vector", v, vec);
		wait_on(2, 1'b1, 40);
		cyc(1);
		chk("response", `RIC_RESP_CYC, resp);
		if (v < 5'h10)
			chk("flag cleared", 0, flags[v]);
	endtask
	task automatic t_debug();
		dbg <= 1'b1;
		exe <= 1'b1;
		opc <= 8'hff;
		cyc(1);
		exe <= 1'b0;
		cyc(3);
		chk("emulation", 0, {srst, cause[4]});
		dbg <= 1'b0;
		exe <= 1'b1;
		opc <= 8'hfe;
		cyc(1);
		exe <= 1'b0;
		cyc(3);
		chk("legal opcode", 0, srst);
		$display("debug done");
	endtask
	// one-cycle events hold reset for the chosen width
	task automatic t_event(input int k);
		int n;
		n = 0;
		wdt <= (k == 0);
		exe <= (k == 1);
		opc <= 8'hff;
		par <= (k == 2);
		mem <= (k == 3);
		cyc(1);
		{wdt, exe, par, mem} <= 4'h0;
		wait_on(0, 1'b1, 2);
		while (srst === 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk("event hold", 1, n >= 15 && n <= 17);
		chk("event cause", 1, cause[bit_i[k]]);
		chk("flags cleared", 0, {flags, insrv});
		$display("event %0d done", k);
	endtask
	task automatic t_level(input int k);
		rpin <= (k == 0);
		por <= (k == 1);
		low_voltage_detector <= (k == 2);
		wait_on(0, 1'b1, 5);
		cyc(30);
		chk("level held", 1, srst);
		chk("level cause", 1, cause[k == 0 ? 0 : k + 1]);
		{rpin, por, low_voltage_detector} <= 3'h0;
		wait_on(0, 1'b0, 25);
		$display("level %0d done", k);
	endtask
	task automatic t_mask();
		ie <= 1'b1;
		preq <= 8'h01;
		cyc(1);
		preq <= 8'h00;
		cyc(10);
		chk("masked", 3'h4, {flags[8], req, stby});
		msk <= 16'hfeff;
		cyc(1);
		chk("standby", 1, stby);
		serve(5'h08, 4'h3);
		chk("group three", 4'h8, insrv);
		ret1();
		chk("popped", 0, insrv);
		$display("mask done");
	endtask
	task automatic t_break();
		ie <= 1'b0;
		msk <= 16'h0000;
		pri <= 32'h0;
		ipin <= 8'h08;
		cyc(10);
		chk("disabled", 2'h2, {flags[3], req});
		software_break_instruction <= 1'b1;
		cyc(1);
		software_break_instruction <= 1'b0;
		serve(5'h10, 4'h0);
		chk("break no push", 0, insrv);
		ie <= 1'b1;
		software_break_instruction <= 1'b1;
		cyc(1);
		software_break_instruction <= 1'b0;
		serve(5'h03, 4'h5);
		serve(5'h10, 4'h0);
		chk("break beside", 4'h1, insrv);
		ret1();
		ipin <= 8'h00;
		$display("break done");
	endtask
	// a second reset in mid-run clears causes and flags
	task automatic t_rerun();
		rst <= 1'b1;
		cyc(2);
		chk("rerun", 8'h80, {srst, cause});
		rst <= 1'b0;
		wait_on(0, 1'b0, 5);
		chk("rerun flags", 0, {flags, insrv, req});
		$display("rerun done");
	endtask
	task automatic t_ties();
		pri <= 32'hffffffff;
		pri[19:18] <= 2'h1;
		pri[25:24] <= 2'h1;
		preq <= 8'h12;
		cyc(1);
		preq <= 8'h00;
		serve(5'h09, 4'h1);
		cyc(4);
		chk("equal waits", 0, req);
		ret1();
		serve(5'h0c, 4'h0);
		ret1();
		pri[21:20] <= 2'h2;
		pri[27:26] <= 2'h0;
		preq <= 8'h24;
		cyc(1);
		preq <= 8'h00;
		serve(5'h0d, 4'h0);
		ret1();
		serve(5'h0a, 4'h2);
		ret1();
		$display("ties done");
	endtask
	task automatic t_nest();
		pri <= 32'hffffffff;
		pri[9:8] <= 2'h2;
		pri[23:22] <= 2'h1;
		ipin <= 8'h10;
		serve(5'h04, 4'h2);
		preq <= 8'h08;
		cyc(1);
		preq <= 8'h00;
		serve(5'h0b, 4'h4);
		chk("nested", 4'h6, insrv);
		ipin <= 8'h30;
		cyc(10);
		chk("lower waits", 0, req);
		ret1();
		cyc(4);
		chk("still waits", 0, req);
		ret1();
		serve(5'h05, 4'h0);
		ret1();
		ipin <= 8'h00;
		$display("nest done");
	endtask
	// reset, then every scenario in turn
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk("in reset", 8'h80, {srst, cause});
		rst <= 1'b0;
		wait_on(0, 1'b0, 5);
		t_debug();
		preq <= 8'h80;
		cyc(1);
		preq <= 8'h00;
		cyc(2);
		chk("pending", 1, flags[15]);
		for (int k = 0; k < 4; k++)
			t_event(k);
		for (int k = 0; k < 3; k++)
			t_level(k);
		t_mask();
		t_break();
		t_ties();
		t_nest();
		t_rerun();
		finish_test();
	end
endmodule
